//--- inc/pllfi_params.svh
// Constants for the PLL fabric-interface behavioural model.
// Assumes a single 100 MHz system clock; included by the package and the RTL.
// What this block does
// R1: Reference picked from four inputs by select.
// R2: Fabric holds reset while changing the select.
// R3: Active-low reset, held at least 10 ns.
// R4: Lock flag rises on lock, drops on loss.
// R5: Internal feedback: out = in*M/(N*O*C).
// R6: Local/core feedback: out = in*M*Cfbk/(N*C), limit 255.
// R7: Fabric returns an output clock as core feedback.
// R8: Three synthesized output clocks for global network.
// R9: Reference source external, core, or dynamic.
// R10: Only local/core feedback aligns outputs to reference; the code also preloads outputs 1 and 2 at that edge in internal mode.
// R11: Phase shifts legal only for given C values.
// R12: Lock low during reset and acquisition; clocks wait.
`ifndef PLLFI_PARAMS_SVH
`define PLLFI_PARAMS_SVH

// ============================================================
// Clock and timing
`define PLLFI_CLK_PERIOD_NS 10
`define PLLFI_RST_MIN_NS 10
`define PLLFI_RST_MIN_CYC ((`PLLFI_RST_MIN_NS + `PLLFI_CLK_PERIOD_NS - 1) / `PLLFI_CLK_PERIOD_NS)
`define PLLFI_LOSS_NS 20000
`define PLLFI_LOSS_CYC (`PLLFI_LOSS_NS / `PLLFI_CLK_PERIOD_NS)
`define PLLFI_LOCK_REF_EDGES 12'h040

// ============================================================
// Widths and limits
`define PLLFI_NUM_REF 4
`define PLLFI_NUM_OUT 3
`define PLLFI_NUM_PIN 6
`define PLLFI_PIN_RST 4
`define PLLFI_PIN_FBK 5
`define PLLFI_SYNC_W 3
`define PLLFI_RATIO_W 20
`define PLLFI_ACC_W 24
`define PLLFI_CNT_W 12
`define PLLFI_FB_PRODUCT_MAX 20'h0_00FF

// ============================================================
// Phase shift codes and legal divider values
`define PLLFI_PH_0 3'h0
`define PLLFI_PH_45 3'h1
`define PLLFI_PH_90 3'h2
`define PLLFI_PH_135 3'h3
`define PLLFI_PH_180 3'h4
`define PLLFI_PH_270 3'h5
`define PLLFI_PH_Q270 3'h6
`define PLLFI_C_TWO 9'h002
`define PLLFI_C_FOUR 9'h004

`endif

//--- inc/pllfi_pkg.sv
// Types for the PLL fabric-interface behavioural model.
// Assumes pllfi_params.svh is on the include path.
`include "pllfi_params.svh"

package pllfi_pkg;

    typedef enum logic [1:0] {
        PLLFI_SRC_EXTERNAL,
        PLLFI_SRC_CORE,
        PLLFI_SRC_DYNAMIC
    } pllfi_src_e;

    typedef enum logic [1:0] {
        PLLFI_FB_INTERNAL,
        PLLFI_FB_LOCAL,
        PLLFI_FB_CORE
    } pllfi_fb_e;

    // Per output: divider C is the value 1..256, phase is a shift code
    typedef struct packed {
        logic enable;
        logic [8:0] div_c;
        logic [2:0] phase;
    } pllfi_out_cfg_s;

    typedef struct packed {
        pllfi_src_e src_mode;
        logic [1:0] static_sel;
        pllfi_fb_e fb_mode;
        logic [1:0] fb_out_sel;
        logic [7:0] mult_m;
        logic [3:0] pre_n;
        logic [1:0] post_o_log2;
        pllfi_out_cfg_s [`PLLFI_NUM_OUT-1:0] outs;
    } pllfi_cfg_s;

    typedef struct packed {
        logic [`PLLFI_NUM_OUT-1:0] clocks;
        logic locked;
        logic cfg_error;
    } pllfi_status_s;

endpackage

//--- rtl/pllfi_out_div.sv
// One synthesized output: a credit accumulator driven by reference edges.
// Assumes ref_edge is a one-cycle pulse in the clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "pllfi_params.svh"

module pllfi_out_div (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic load,
    input wire logic ref_edge,
    // Ratio and phase
    input wire logic [`PLLFI_RATIO_W-1:0] num,
    input wire logic [`PLLFI_RATIO_W-1:0] den,
    input wire logic [2:0] quarters,
    // Output clock
    output logic clk_out
);

    logic signed [`PLLFI_ACC_W-1:0] acc_q, acc_d;
    logic clk_q;
    wire signed [`PLLFI_ACC_W-1:0] credit = ref_edge ?
        $signed({{(`PLLFI_ACC_W-`PLLFI_RATIO_W-1){1'b0}}, num, 1'b0}) : '0;
    wire signed [`PLLFI_ACC_W-1:0] den_s = $signed({{(`PLLFI_ACC_W-`PLLFI_RATIO_W){1'b0}}, den});
    wire signed [`PLLFI_ACC_W-1:0] acc_add = acc_q + credit;
    wire toggle = acc_add >= den_s;
    // Phase delay: each quarter is a quarter of a half period, taken as a debt
    wire [`PLLFI_ACC_W-1:0] delay_prod = `PLLFI_ACC_W'(den) * `PLLFI_ACC_W'(quarters);
    wire signed [`PLLFI_ACC_W-1:0] preload = -$signed(delay_prod >> 2);

    // Limitation: at most one toggle a cycle, so outputs above 50 MHz fall behind
    assign acc_d = toggle ? acc_add - den_s : acc_add; // R5 R6

    always_ff @(posedge clock) begin
        if (rst || !run) begin
            acc_q <= '0;
            clk_q <= 1'b0;
        end else if (load) begin
            acc_q <= preload; // R11
            clk_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            clk_q <= clk_q ^ toggle;
        end
    end

    assign clk_out = clk_q;

endmodule

`default_nettype wire

//--- rtl/pllfi_top.sv
// Behavioural PLL as seen from the fabric: reference select, reset, lock, three clocks.
// Assumes pins arrive asynchronously and the configuration is steady while running.
`timescale 1ns/1ps
`default_nettype none
`include "pllfi_params.svh"

module pllfi_top (
    // System clock and reset
    input wire logic clock,
    input wire logic rst,
    // Reference and feedback pins
    input wire logic [`PLLFI_NUM_REF-1:0] ref_clock_inputs,
    input wire logic [1:0] ref_source_select,
    input wire logic pll_reset_low,
    input wire logic fabric_feedback_clock,
    // Static configuration
    input wire pllfi_pkg::pllfi_cfg_s cfg,
    // Outputs to the global clock network and lock monitor
    output pllfi_pkg::pllfi_status_s status
);

    typedef enum logic [1:0] {
        PLLFI_ST_RESET,
        PLLFI_ST_ACQUIRE,
        PLLFI_ST_LOCKED
    } pllfi_state_e;

    // ============================================================
    // Helpers
    function automatic logic [2:0] phase_quarters(input logic [2:0] code);
        case (code)
            `PLLFI_PH_45: phase_quarters = 3'h1;
            `PLLFI_PH_90: phase_quarters = 3'h2;
            `PLLFI_PH_135: phase_quarters = 3'h3;
            `PLLFI_PH_180: phase_quarters = 3'h4;
            `PLLFI_PH_270: phase_quarters = `PLLFI_PH_Q270;
            default: phase_quarters = 3'h0;
        endcase
    endfunction

    function automatic logic phase_ok(input logic [2:0] code, input logic [8:0] c);
        case (code)
            `PLLFI_PH_0: phase_ok = 1'b1;
            `PLLFI_PH_45, `PLLFI_PH_135: phase_ok = (c == `PLLFI_C_FOUR); // R11
            `PLLFI_PH_90: phase_ok = (c == `PLLFI_C_TWO) || (c == `PLLFI_C_FOUR); // R11
            `PLLFI_PH_180, `PLLFI_PH_270: phase_ok = (c == `PLLFI_C_TWO); // R11
            default: phase_ok = 1'b0;
        endcase
    endfunction

    // Field value 0 stands for 256
    function automatic logic [`PLLFI_RATIO_W-1:0] div_value(input logic [8:0] c);
        div_value = (c[7:0] == 8'h00) ? `PLLFI_RATIO_W'(9'h100) : `PLLFI_RATIO_W'(c[7:0]);
    endfunction

    // ============================================================
    // Pin synchronisers: three stages, a change counts when stages two and three agree
    wire [`PLLFI_NUM_PIN-1:0] pins = {fabric_feedback_clock, pll_reset_low, ref_clock_inputs};
    logic [`PLLFI_NUM_PIN-1:0] sync1_q, sync2_q, sync3_q, settled_q;
    logic [`PLLFI_NUM_PIN-1:0] rise;

    genvar gi;
    generate
        for (gi = 0; gi < `PLLFI_NUM_PIN; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (rst) begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                    sync3_q[gi] <= 1'b1;
                    settled_q[gi] <= 1'b1;
                end else begin
                    sync1_q[gi] <= pins[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        settled_q[gi] <= sync3_q[gi];
                    end
                end
            end
            assign rise[gi] = sync2_q[gi] && sync3_q[gi] && !settled_q[gi];
        end
    endgenerate

    // ============================================================
    // Reference source selection
    wire pllfi_pkg::pllfi_src_e src_mode = cfg.src_mode;
    // Pin sources on inputs 0..1, fabric sources on inputs 2..3
    wire [1:0] ref_index = (src_mode == pllfi_pkg::PLLFI_SRC_DYNAMIC) ? ref_source_select : // R1 R9
                           (src_mode == pllfi_pkg::PLLFI_SRC_CORE) ? {1'b1, cfg.static_sel[0]} : // R9
                           {1'b0, cfg.static_sel[0]}; // R9
    wire ref_edge = rise[ref_index]; // R1
    wire fbk_edge = rise[`PLLFI_PIN_FBK];

    // Reset counts only after the low level has held its minimum width
    wire rst_low_seen = !sync2_q[`PLLFI_PIN_RST] && !sync3_q[`PLLFI_PIN_RST];
    logic [`PLLFI_CNT_W-1:0] rst_run_q;
    // One wider so the minimum of one cycle never folds into an always-true compare
    wire [`PLLFI_CNT_W:0] rst_low_cycles = {1'b0, rst_run_q} + (`PLLFI_CNT_W+1)'(1);
    wire pll_in_reset = rst_low_seen && (rst_low_cycles >= (`PLLFI_CNT_W+1)'(`PLLFI_RST_MIN_CYC)); // R3

    // ============================================================
    // Ratio and configuration checks
    wire pllfi_pkg::pllfi_fb_e fb_mode = cfg.fb_mode;
    wire fb_external = (fb_mode != pllfi_pkg::PLLFI_FB_INTERNAL);
    wire [`PLLFI_RATIO_W-1:0] post_o = `PLLFI_RATIO_W'(1) << cfg.post_o_log2;
    wire [`PLLFI_RATIO_W-1:0] pre_n = `PLLFI_RATIO_W'(cfg.pre_n);
    wire [`PLLFI_RATIO_W-1:0] mult_m = `PLLFI_RATIO_W'(cfg.mult_m);
    wire [1:0] fb_idx = (cfg.fb_out_sel == 2'h3) ? 2'h2 : cfg.fb_out_sel;
    wire [`PLLFI_RATIO_W-1:0] div_fbk = div_value(cfg.outs[fb_idx].div_c);
    wire [`PLLFI_RATIO_W-1:0] fb_product = `PLLFI_RATIO_W'(mult_m * post_o * div_fbk);
    wire [`PLLFI_RATIO_W-1:0] num = fb_external ? `PLLFI_RATIO_W'(mult_m * div_fbk) : mult_m; // R5 R6

    logic [`PLLFI_NUM_OUT-1:0] out_ok;
    logic [`PLLFI_RATIO_W-1:0] den [`PLLFI_NUM_OUT];
    generate
        for (gi = 0; gi < `PLLFI_NUM_OUT; gi++) begin : g_ratio
            wire [`PLLFI_RATIO_W-1:0] div_c = div_value(cfg.outs[gi].div_c);
            assign den[gi] = fb_external ? `PLLFI_RATIO_W'(pre_n * div_c) : // R6
                                           `PLLFI_RATIO_W'(pre_n * post_o * div_c); // R5
            assign out_ok[gi] = phase_ok(cfg.outs[gi].phase, cfg.outs[gi].div_c);
        end
    endgenerate

    wire cfg_error = (cfg.pre_n == 4'h0) || (cfg.mult_m == 8'h00) || !(&out_ok) ||
                     (src_mode == pllfi_pkg::PLLFI_SRC_DYNAMIC + 2'h1) ||
                     (fb_external && (fb_product > `PLLFI_FB_PRODUCT_MAX)); // R6 R11
    // Core feedback must come back through the fabric; the chosen output must be running
    wire fbk_needed = (fb_mode == pllfi_pkg::PLLFI_FB_CORE); // R7

    // ============================================================
    // Lock state machine
    pllfi_state_e state_q, state_d;
    logic [`PLLFI_CNT_W-1:0] edges_q, ref_idle_q, fbk_idle_q;
    logic [1:0] sel_q;
    logic locked_q;

    wire sel_changed = (ref_index != sel_q);
    wire ref_lost = (ref_idle_q >= `PLLFI_CNT_W'(`PLLFI_LOSS_CYC));
    wire fbk_lost = fbk_needed && (fbk_idle_q >= `PLLFI_CNT_W'(`PLLFI_LOSS_CYC));
    // Select moved without a reset: treated as a loss of lock
    wire lock_lost = ref_lost || fbk_lost || sel_changed || cfg_error; // R4 R2
    wire acquired = ref_edge && (edges_q >= `PLLFI_LOCK_REF_EDGES - 12'h001);
    wire start_out = (state_q == PLLFI_ST_ACQUIRE) && acquired && !lock_lost;

    always_comb begin
        state_d = state_q;
        case (state_q)
            PLLFI_ST_RESET: begin
                if (!pll_in_reset) begin
                    state_d = PLLFI_ST_ACQUIRE;
                end
            end
            PLLFI_ST_ACQUIRE: begin
                if (pll_in_reset) begin
                    state_d = PLLFI_ST_RESET;
                end else if (start_out) begin
                    state_d = PLLFI_ST_LOCKED; // R4 R12
                end
            end
            PLLFI_ST_LOCKED: begin
                if (pll_in_reset) begin
                    state_d = PLLFI_ST_RESET; // R3
                end else if (lock_lost) begin
                    state_d = PLLFI_ST_ACQUIRE; // R4
                end
            end
            default: state_d = PLLFI_ST_RESET;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= PLLFI_ST_RESET;
            locked_q <= 1'b0;
            sel_q <= 2'h0;
            rst_run_q <= '0;
        end else begin
            state_q <= state_d;
            locked_q <= (state_d == PLLFI_ST_LOCKED); // R4 R12
            sel_q <= ref_index;
            rst_run_q <= rst_low_seen ? rst_run_q + ((&rst_run_q) ? `PLLFI_CNT_W'(0) : `PLLFI_CNT_W'(1)) : '0;
        end
    end

    // Edge count restarts outside acquisition or on any loss; reference watchdog restarts in reset or on its edge, feedback watchdog whenever unlocked or on its edge
    always_ff @(posedge clock) begin
        if (rst || state_q != PLLFI_ST_ACQUIRE || lock_lost) begin
            edges_q <= '0;
        end else if (ref_edge && !(&edges_q)) begin
            edges_q <= edges_q + `PLLFI_CNT_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst || state_q == PLLFI_ST_RESET || ref_edge) begin
            ref_idle_q <= '0;
        end else if (!ref_lost) begin
            ref_idle_q <= ref_idle_q + `PLLFI_CNT_W'(1);
        end
    end

    // Feedback is only watched once clocks run, since it comes from our own outputs
    always_ff @(posedge clock) begin
        if (rst || state_q != PLLFI_ST_LOCKED || fbk_edge) begin
            fbk_idle_q <= '0;
        end else if (!fbk_lost) begin
            fbk_idle_q <= fbk_idle_q + `PLLFI_CNT_W'(1);
        end
    end

    // ============================================================
    // Output dividers: run only while locked; preloaded on a reference edge, all in local/core, outputs 1 and 2 only in internal
    wire run = (state_q == PLLFI_ST_LOCKED) || start_out; // R12
    wire load = start_out && fb_external; // R10
    logic [`PLLFI_NUM_OUT-1:0] clk_div;

    generate
        for (gi = 0; gi < `PLLFI_NUM_OUT; gi++) begin : g_out
            pllfi_out_div u_div (
                .clock(clock),
                .rst(rst),
                .run(run && cfg.outs[gi].enable),
                .load(load || (start_out && !fb_external && gi != 0)), // R10
                .ref_edge(ref_edge && !start_out),
                .num(num),
                .den(den[gi]),
                .quarters(phase_quarters(cfg.outs[gi].phase)),
                .clk_out(clk_div[gi])
            ); // R8
        end
    endgenerate

    assign status.clocks = clk_div; // R8
    assign status.locked = locked_q;
    assign status.cfg_error = cfg_error;

endmodule

`default_nettype wire

//--- dv/pllfi_top_asserts.sv
// Checker for the PLL fabric-interface model, bound to its top ports.
// Assumes one clock domain and a synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none

module pllfi_top_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Block inputs
    input wire logic [3:0] ref_clock_inputs,
    input wire logic [1:0] ref_source_select,
    input wire logic pll_reset_low,
    input wire logic fabric_feedback_clock,
    input wire pllfi_pkg::pllfi_cfg_s cfg,
    // Block outputs
    input wire pllfi_pkg::pllfi_status_s status
);
    // ============================================================
    // Helper logic
    logic [11:0] since_q;
    logic [11:0] since_d;
    logic [1:0] tap;
    logic [8:0] cfbk;
    logic [19:0] fb_prod;
    logic [8:0] c0;
    logic [2:0] ph;
    logic ph_bad;
    // Cycles since the pin was last low; saturates instead of wrapping
    assign since_d = !pll_reset_low ? 12'h000 : (since_q == 12'hfff) ? since_q : since_q + 12'h001;
    assign tap = (cfg.fb_out_sel == 2'h3) ? 2'h2 : cfg.fb_out_sel;
    assign cfbk = (cfg.outs[tap].div_c == 9'h000) ? 9'h100 : cfg.outs[tap].div_c;
    assign fb_prod = ({12'h000, cfg.mult_m} << cfg.post_o_log2) * {11'h000, cfbk};
    assign c0 = cfg.outs[0].div_c;
    assign ph = cfg.outs[0].phase;
    assign ph_bad = cfg.outs[0].enable && (((ph == 3'h4 || ph == 3'h5) && c0 != 9'h002) ||
        ((ph == 3'h1 || ph == 3'h3) && c0 != 9'h004) || (ph == 3'h2 && c0 != 9'h002 && c0 != 9'h004));
    always_ff @(posedge clock) begin
        since_q <= rst ? 12'h000 : since_d;
    end

    // ============================================================
    // Properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_bad_nm;
        (cfg.pre_n == 4'h0 || cfg.mult_m == 8'h00) |-> status.cfg_error;
    endproperty
    a_bad_nm: assert property (p_bad_nm) else $error("zero divider not flagged");
    property p_fb_limit;
        (cfg.fb_mode != pllfi_pkg::PLLFI_FB_INTERNAL && fb_prod > 20'h0_00ff) |-> status.cfg_error;
    endproperty
    a_fb_limit: assert property (p_fb_limit) else $error("feedback product over limit");
    property p_src_bad;
        cfg.src_mode == 2'h3 |-> status.cfg_error;
    endproperty
    a_src_bad: assert property (p_src_bad) else $error("bad source mode not flagged");
    property p_phase;
        ph_bad |-> status.cfg_error;
    endproperty
    a_phase: assert property (p_phase) else $error("bad phase divider not flagged");
    property p_err_blocks;
        status.cfg_error [*2] |=> !status.locked;
    endproperty
    a_err_blocks: assert property (p_err_blocks) else $error("locked with bad config");
    property p_reset_drops;
        !pll_reset_low [*5] |=> !status.locked;
    endproperty
    a_reset_drops: assert property (p_reset_drops) else $error("locked while held in reset");
    property p_idle_clocks;
        !status.locked [*2] |-> status.clocks == 3'h0;
    endproperty
    a_idle_clocks: assert property (p_idle_clocks) else $error("clocks run unlocked");
    property p_lock_time;
        $rose(status.locked) |-> since_q >= 12'h0c8;
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("lock came too early");
    c_lock: cover property ($rose(status.locked));
    c_drop: cover property ($fell(status.locked));
    c_err: cover property (status.cfg_error);
    c_clk: cover property ($rose(status.clocks[1]));
endmodule

bind pllfi_top pllfi_top_asserts u_asserts (.clock(clock), .rst(rst), .ref_clock_inputs(ref_clock_inputs),
    .ref_source_select(ref_source_select), .pll_reset_low(pll_reset_low),
    .fabric_feedback_clock(fabric_feedback_clock), .cfg(cfg), .status(status));
`default_nettype wire

//--- dv/pllfi_fabric_model.sv
// Fabric side: reference clocks, reset pin, select and feedback return.
// Assumes the bench calls hold and release_pll around select changes.
`timescale 1ns/1ps
`default_nettype none

module pllfi_fabric_model (
    // Clock
    input wire logic clock,
    // From the block
    input wire logic [2:0] clocks_out,
    input wire logic [1:0] fb_tap,
    // To the block
    output logic [3:0] ref_clk,
    output logic [1:0] sel,
    output logic rst_low,
    output logic fb_clk
);
    // ============================================================
    // Reference generators
    logic [3:0] ref_run = 4'h1;
    logic fb_on = 1'b1;
    int half [4] = '{3, 4, 5, 6};
    int cnt [4] = '{0, 0, 0, 0};
    initial begin
        ref_clk = 4'h0;
        sel = 2'h0;
        rst_low = 1'b0;
    end
    // A stopped reference freezes, like a gated source
    always @(negedge clock) begin
        for (int i = 0; i < 4; i++) begin
            if (ref_run[i]) begin
                cnt[i] = cnt[i] + 1;
                if (cnt[i] >= half[i]) begin
                    cnt[i] = 0;
                    ref_clk[i] = ~ref_clk[i];
                end
            end
        end
    end
    assign fb_clk = fb_on & clocks_out[(fb_tap == 2'h3) ? 2'h2 : fb_tap];

    // ============================================================
    // Reset and select sequencing
    task automatic hold();
        @(negedge clock);
        rst_low = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task automatic release_pll(input logic [1:0] s);
        sel = s;
        repeat (2) @(negedge clock);
        rst_low = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the PLL fabric-interface model.
// Assumes the fabric model drives all pins; cfg is owned here.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clock;
    logic rst;
    logic [3:0] ref_clks;
    logic [1:0] sel;
    logic rst_low;
    logic fb_clk;
    pllfi_pkg::pllfi_cfg_s cfg;
    pllfi_pkg::pllfi_status_s status;
    int n_errors = 0;
    int n_tests = 0;
    // {fb, m, n, olog, c0, c1, out, rises in 24 ref periods}
    int ft [5][8] = '{'{0, 2, 1, 0, 4, 4, 0, 12}, '{0, 3, 1, 1, 4, 3, 1, 12}, '{1, 2, 1, 0, 4, 8, 1, 24},
        '{2, 2, 1, 0, 4, 8, 1, 24}, '{0, 4, 3, 0, 2, 4, 0, 16}};
    // {src, fb, m, n, c0, phase code, error}
    int et [16][7] = '{'{3, 0, 2, 1, 4, 0, 1}, '{0, 0, 2, 0, 4, 0, 1}, '{0, 1, 255, 1, 2, 0, 1},
        '{0, 1, 255, 1, 1, 0, 0}, '{0, 0, 2, 1, 2, 4, 0}, '{0, 0, 2, 1, 4, 4, 1}, '{0, 0, 2, 1, 2, 5, 0},
        '{0, 0, 2, 1, 4, 5, 1}, '{0, 0, 2, 1, 4, 1, 0}, '{0, 0, 2, 1, 2, 1, 1}, '{0, 0, 2, 1, 4, 3, 0},
        '{0, 0, 2, 1, 2, 3, 1}, '{0, 0, 2, 1, 2, 2, 0}, '{0, 0, 2, 1, 4, 2, 0}, '{0, 0, 2, 1, 8, 2, 1},
        '{0, 0, 2, 1, 8, 0, 0}};

    pllfi_top dut (.clock(clock), .rst(rst), .ref_clock_inputs(ref_clks), .ref_source_select(sel),
        .pll_reset_low(rst_low), .fabric_feedback_clock(fb_clk), .cfg(cfg), .status(status));
    pllfi_fabric_model fab (.clock(clock), .clocks_out(status.clocks), .fb_tap(cfg.fb_out_sel),
        .ref_clk(ref_clks), .sel(sel), .rst_low(rst_low), .fb_clk(fb_clk));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ============================================================
    // Helpers
    function automatic pllfi_pkg::pllfi_cfg_s mk(input int src, input int ssel, input int fb, input int m,
        input int n, input int olog, input int c0, input int c1, input int ph);
        pllfi_pkg::pllfi_cfg_s c;
        c = '0;
        c.src_mode = pllfi_pkg::pllfi_src_e'(src);
        c.static_sel = 2'(ssel);
        c.fb_mode = pllfi_pkg::pllfi_fb_e'(fb);
        c.mult_m = 8'(m);
        c.pre_n = 4'(n);
        c.post_o_log2 = 2'(olog);
        c.outs[0] = {1'b1, 9'(c0), 3'(ph)};
        c.outs[1] = {1'b1, 9'(c1), 3'h0};
        c.outs[2] = {1'b1, 9'(c1), 3'h0};
        return c;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Bounded wait for the lock flag; running out ends the run
    task automatic wait_level(input logic lvl, input int bound, output int took);
        took = 0;
        while (status.locked !== lvl && took < bound) begin
            @(negedge clock);
            took++;
        end
        if (status.locked !== lvl) begin
            n_errors++;
            $display("BAD t=%0t lock flag wait ran out", $time);
            tally_and_finish();
        end
    endtask
    task automatic count_rises(input int idx, input int cycles, output int rises);
        logic prev;
        rises = 0;
        prev = status.clocks[idx];
        repeat (cycles) begin
            @(negedge clock);
            if (status.clocks[idx] === 1'b1 && prev === 1'b0) rises++;
            prev = status.clocks[idx];
        end
    endtask

    // ============================================================
    // Tests
    initial begin
        int took;
        int rises;
        rst = 1'b1;
        cfg = mk(0, 0, 0, 2, 1, 0, 4, 4, 0);
        repeat (5) @(negedge clock);
        check(status.locked, 1'b0);
        rst = 1'b0;
        for (int k = 0; k < 8; k++) begin
            fab.hold();
            cfg = mk(k < 4 ? k / 2 : 2, k % 2, 0, 2, 1, 0, 4, 4, 0);
            fab.ref_run = ~(4'h1 << k[1:0]);
            fab.release_pll(k[1:0]);
            repeat (900) @(negedge clock);
            check(status.locked, 1'b0);
            fab.ref_run = 4'h1 << k[1:0];
            wait_level(1'b1, 1200, took);
            check(took >= 120 * fab.half[k[1:0]], 1'b1);
            if (k == 7) begin
                fab.sel = 2'h2;
                repeat (2) @(negedge clock);
                check(status.locked, 1'b0);
            end
        end
        $display("sources done");
        for (int i = 0; i < 5; i++) begin
            fab.hold();
            cfg = mk(0, 0, ft[i][0], ft[i][1], ft[i][2], ft[i][3], ft[i][4], ft[i][5], 0);
            fab.ref_run = 4'h1;
            fab.release_pll(2'h0);
            wait_level(1'b1, 600, took);
            repeat (20) @(negedge clock);
            count_rises(ft[i][6], 144, rises);
            check(rises >= ft[i][7] - 1 && rises <= ft[i][7] + 1, 1'b1);
        end
        $display("frequencies done");
        // Local mode, output 0 shifted 180 degrees against output 1 at C of 2
        fab.hold();
        cfg = mk(0, 0, 1, 1, 2, 0, 2, 2, 4);
        fab.release_pll(2'h0);
        wait_level(1'b1, 600, took);
        repeat (20) @(negedge clock);
        for (int i = 0; i < 4; i++) begin
            check(status.clocks[0], !status.clocks[1]);
            repeat (5) @(negedge clock);
        end
        $display("phase shift done");
        for (int i = 0; i < 16; i++) begin
            fab.hold();
            cfg = mk(et[i][0], 0, et[i][1], et[i][2], et[i][3], 0, et[i][4], 4, et[i][5]);
            fab.release_pll(2'h0);
            check(status.cfg_error, et[i][6][0]);
            repeat (800) @(negedge clock);
            check(status.locked, !et[i][6][0]);
        end
        $display("config errors done");
        for (int j = 0; j < 2; j++) begin
            fab.hold();
            // Core mode first, then internal, both at half the reference rate, so the returned clock is slow enough to sync
            cfg = mk(0, 0, j == 0 ? 2 : 0, j == 0 ? 1 : 2, j == 0 ? 2 : 1, 0, 4, 4, 0);
            fab.fb_on = 1'b1;
            fab.release_pll(2'h0);
            wait_level(1'b1, 600, took);
            repeat (2100) @(negedge clock);
            check(status.locked, 1'b1);
            if (j == 0) fab.fb_on = 1'b0;
            else fab.ref_run = 4'h0;
            repeat (1000) @(negedge clock);
            check(status.locked, 1'b1);
            wait_level(1'b0, 1300, took);
            repeat (2) @(negedge clock);
            check(status.clocks, 3'h0);
            fab.ref_run = 4'h1;
        end
        $display("loss of lock done");
        fab.hold();
        fab.release_pll(2'h0);
        wait_level(1'b1, 600, took);
        fab.rst_low = 1'b0;
        repeat (2) @(negedge clock);
        fab.rst_low = 1'b1;
        repeat (6) @(negedge clock);
        check(status.locked, 1'b0);
        $display("reset pulse done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
